// [verilog/smr_top.sv]
// Local design decisions: the address map and the Avalon-MM register port.
`timescale 1ns/1ps
module smr_top (
   input  wire logic        core_clk_i,
   input  wire logic        rst_n_i,
   input  wire logic [5:0]  avs_address_i,
   input  wire logic        avs_read_i,
   input  wire logic        avs_write_i,
   input  wire logic [31:0] avs_writedata_i,
   output logic [31:0]      avs_readdata_o,
   output logic             avs_waitrequest_o,
   input  wire logic        data_line_i,
   output logic             data_line_o,
   output logic             data_line_oe_o,
   output logic             clock_line_o,
   output logic             clock_line_oe_o,
   output logic             irq_o
);
   typedef enum {SMR_IDLE, SMR_LOW, SMR_HIGH, SMR_DONE} smr_state_t;

   smr_state_t  state_q;
   logic [10:0] ctrl_q;
   logic [7:0]  div_lo_q;
   logic [7:0]  div_hi_q;
   logic [1:0]  int_st_q;
   logic [1:0]  int_mask_q;
   logic        overrun_q;
   logic        rx_flag_q;
   logic [8:0]  shift_q;
   logic [3:0]  bit_cnt_q;
   logic [3:0]  samples_q;
   logic        ack_q;
   logic        char_done;
   logic        fifo_pop;
   logic        tick;
   logic [8:0]  head;
   logic [1:0]  count;
   logic        port_on;
   logic        master_on;
   logic        receiving;
   logic [5:0]  prescale;
   logic        fifo_clr;
   logic        wr_ctrl;
   logic        rd_data;
   logic [3:0]  char_bits;
   logic        rx_irq_en;

   assign port_on   = ctrl_q[smr_pkg::PORT_EN_BIT];
   assign master_on = ctrl_q[smr_pkg::CLOCKED_MODE_BIT] && port_on
                      && ctrl_q[smr_pkg::MASTER_CLK_BIT];
   assign receiving = master_on && !overrun_q
                      && (ctrl_q[smr_pkg::SINGLE_RX_BIT] || ctrl_q[smr_pkg::CONT_RX_BIT]);
   assign char_bits = ctrl_q[smr_pkg::NINTH_RX_BIT] ? 4'h9 : 4'h8;
   assign wr_ctrl   = avs_write_i && ack_q == 1'b1 && avs_address_i == smr_pkg::A_CTRL;
   assign rd_data   = avs_read_i && ack_q == 1'b0 && avs_address_i == smr_pkg::A_DATA;
   assign fifo_pop  = rd_data;
   assign fifo_clr  = !rst_n_i || !port_on;
   assign char_done = state_q == SMR_HIGH && tick && bit_cnt_q == char_bits - 4'h1;
   assign rx_irq_en = ctrl_q[smr_pkg::RX_INT_EN_BIT] && ctrl_q[smr_pkg::GLOBAL_INT_EN_BIT]
                      && ctrl_q[smr_pkg::PERIPH_INT_EN_BIT];

   // Clocked mode and async fast use /4, async slow wide /16, async slow narrow /64
   always_comb begin
      if (ctrl_q[smr_pkg::CLOCKED_MODE_BIT]) begin
         // Two ticks per bit in clocked mode, so each clock half takes half the prescale
         prescale = smr_pkg::PRESCALE_SYNC >> 1;
      end else if (ctrl_q[smr_pkg::HIGH_SPEED_BIT]) begin
         prescale = smr_pkg::PRESCALE_SYNC;
      end else if (ctrl_q[smr_pkg::WIDE_DIV_BIT]) begin
         prescale = smr_pkg::PRESCALE_SLOW;
      end else begin
         prescale = smr_pkg::PRESCALE_NARROW;
      end
   end

   smr_baud_gen u_baud (
      .core_clk_i (core_clk_i),
      .run_i      (receiving && rst_n_i),
      .divisor_i  (ctrl_q[smr_pkg::WIDE_DIV_BIT] ? {div_hi_q, div_lo_q} : {8'h00, div_lo_q}),
      .prescale_i (prescale),
      .tick_o     (tick)
   );

   smr_rx_fifo u_fifo (
      .core_clk_i  (core_clk_i),
      .clr_i       (fifo_clr),
      .push_i      (char_done && count != 2'h2),
      .push_data_i (ctrl_q[smr_pkg::NINTH_RX_BIT] ? shift_q : {1'b0, shift_q[8:1]}),
      .pop_i       (fifo_pop),
      .head_o      (head),
      .count_o     (count)
   );

   // Control register; single enable self-clears after a character unless the continuous enable is also set
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         ctrl_q <= smr_pkg::CTRL_RST;
      end else if (wr_ctrl) begin
         ctrl_q <= avs_writedata_i[smr_pkg::CTRL_W-1:0];
      end else if (char_done && !ctrl_q[smr_pkg::CONT_RX_BIT]) begin
         ctrl_q[smr_pkg::SINGLE_RX_BIT] <= 1'b0;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         div_lo_q <= smr_pkg::DIV_RST;
         div_hi_q <= smr_pkg::DIV_RST;
      end else if (avs_write_i && ack_q == 1'b1) begin
         if (avs_address_i == smr_pkg::A_DIV_LO) begin
            div_lo_q <= avs_writedata_i[7:0];
         end
         if (avs_address_i == smr_pkg::A_DIV_HI) begin
            div_hi_q <= avs_writedata_i[7:0];
         end
      end
   end

   // Receive sequencer: clock low half then high half, sample on rising edge
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i || !receiving) begin
         state_q   <= SMR_IDLE;
         bit_cnt_q <= 4'h0;
      end else begin
         case (state_q)
            SMR_IDLE: begin
               state_q   <= SMR_LOW;
               bit_cnt_q <= 4'h0;
            end
            SMR_LOW: begin
               if (tick) begin
                  state_q <= SMR_HIGH;
               end
            end
            SMR_HIGH: begin
               if (tick) begin
                  if (bit_cnt_q == char_bits - 4'h1) begin
                     state_q <= SMR_DONE;
                  end else begin
                     bit_cnt_q <= bit_cnt_q + 4'h1;
                     state_q   <= SMR_LOW;
                  end
               end
            end
            SMR_DONE: begin
               state_q <= SMR_IDLE;
            end
            default: begin
               state_q <= SMR_IDLE;
            end
         endcase
      end
   end

   // Bits arrive least significant first
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         shift_q <= 9'h000;
      end else if (state_q == SMR_LOW && tick) begin
         shift_q <= {data_line_i, shift_q[8:1]};
      end
   end

   // Samples taken in the current character, counted apart from the bit counter
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i || state_q == SMR_IDLE) begin
         samples_q <= 4'h0;
      end else if (state_q == SMR_LOW && tick) begin
         samples_q <= samples_q + 4'h1;
      end
   end

   // Overrun: third complete character while two are stored; cleared by clearing the
   // continuous enable, by port disable, or by a data read when it came from a single receive
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i || !port_on) begin
         overrun_q <= 1'b0;
      end else if (char_done && count == 2'h2) begin
         overrun_q <= 1'b1;
      end else if (wr_ctrl && !avs_writedata_i[smr_pkg::CONT_RX_BIT]) begin
         overrun_q <= 1'b0;
      end else if (char_done && count == 2'h2) begin
         overrun_q <= 1'b1;
      end else if (rd_data && !ctrl_q[smr_pkg::CONT_RX_BIT]) begin
         overrun_q <= 1'b0;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         rx_flag_q <= 1'b0;
      end else begin
         rx_flag_q <= (count != 2'h0) || (char_done && count != 2'h2);
      end
   end

   // Sticky interrupt status, write one to clear; a set wins
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         int_st_q   <= 2'h0;
         int_mask_q <= smr_pkg::MASK_RST;
      end else begin
         if (avs_write_i && ack_q == 1'b1 && avs_address_i == smr_pkg::A_INT_MASK) begin
            int_mask_q <= avs_writedata_i[1:0];
         end
         int_st_q <= (int_st_q & ~((avs_write_i && ack_q == 1'b1 && avs_address_i == smr_pkg::A_INT_ST)
                     ? avs_writedata_i[1:0] : 2'h0))
                     | {char_done && count == 2'h2, char_done && count != 2'h2};
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= (rx_flag_q && rx_irq_en) || |(int_st_q & int_mask_q);
      end
   end

   // Clock line and shared data line direction
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         clock_line_o    <= 1'b0;
         clock_line_oe_o <= 1'b0;
         data_line_o     <= 1'b0;
         data_line_oe_o  <= 1'b0;
      end else begin
         clock_line_oe_o <= master_on;
         clock_line_o    <= state_q == SMR_HIGH;
         data_line_o     <= 1'b0;
         data_line_oe_o  <= 1'b0;
      end
   end

   // Avalon slave: one wait cycle; writes land on the second edge, reads are taken on the first
   // Waitrequest idles high so it can come straight from a flop
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         ack_q             <= 1'b0;
         avs_waitrequest_o <= 1'b1;
         avs_readdata_o    <= 32'h0000_0000;
      end else begin
         ack_q             <= (avs_read_i || avs_write_i) && !ack_q;
         avs_waitrequest_o <= !((avs_read_i || avs_write_i) && !ack_q);
         if (avs_read_i && !ack_q) begin
            case (avs_address_i)
               smr_pkg::A_CTRL:     avs_readdata_o <= {21'h0, ctrl_q};
               smr_pkg::A_DIV_LO:   avs_readdata_o <= {24'h0, div_lo_q};
               smr_pkg::A_DIV_HI:   avs_readdata_o <= {24'h0, div_hi_q};
               smr_pkg::A_STATUS:   avs_readdata_o <= {27'h0, count, rx_flag_q, overrun_q,
                                                       head[8]};
               smr_pkg::A_DATA:     avs_readdata_o <= {24'h0, head[7:0]};
               smr_pkg::A_INT_ST:   avs_readdata_o <= {30'h0, int_st_q};
               smr_pkg::A_INT_MASK: avs_readdata_o <= {30'h0, int_mask_q};
               default:             avs_readdata_o <= 32'h0000_0000;
            endcase
         end
      end
   end

   clock_gate_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      clock_line_oe_o |-> $past(master_on))
      else $error("Clock line driven outside master mode");
   single_stop_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      char_done && !ctrl_q[smr_pkg::CONT_RX_BIT] && !wr_ctrl |=> !ctrl_q[smr_pkg::SINGLE_RX_BIT])
      else $error("Single enable not cleared");
   overrun_set_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      char_done && count == 2'h2 && port_on |=> overrun_q)
      else $error("Overrun not flagged");
   overrun_clr_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      !port_on |=> !overrun_q && count == 2'h0)
      else $error("Port disable did not reset");
   flag_set_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      char_done && count != 2'h2 && !fifo_clr |=> rx_flag_q)
      else $error("Receive flag not set");
   irq_gate_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      irq_o && $past(int_st_q & int_mask_q) == 2'h0 |-> $past(rx_irq_en))
      else $error("Interrupt without all enables");
   no_drive_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      !data_line_oe_o)
      else $error("Data line driven while receiving");
   bit_count_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      char_done |-> samples_q == (ctrl_q[smr_pkg::NINTH_RX_BIT] ? 4'h9 : 4'h8))
      else $error("Wrong character length");
endmodule

// [verilog/smr_pkg.sv]
package smr_pkg;
   // Register byte offsets
   localparam logic [3:0] CTRL_OFF    = 4'h0;
   localparam logic [3:0] DIV_LO_OFF  = 4'h4;
   localparam logic [3:0] DIV_HI_OFF  = 4'h8;
   localparam logic [3:0] STATUS_OFF  = 4'hc;
   localparam logic [3:0] DATA_OFF    = 4'h0;
   localparam logic [3:0] INT_ST_OFF  = 4'h0;
   localparam logic [5:0] A_CTRL      = 6'h00;
   localparam logic [5:0] A_DIV_LO    = 6'h04;
   localparam logic [5:0] A_DIV_HI    = 6'h08;
   localparam logic [5:0] A_STATUS    = 6'h0c;
   localparam logic [5:0] A_DATA      = 6'h10;
   localparam logic [5:0] A_INT_ST    = 6'h14;
   localparam logic [5:0] A_INT_MASK  = 6'h18;
   // Control register field positions
   localparam int CLOCKED_MODE_BIT  = 0;
   localparam int PORT_EN_BIT       = 1;
   localparam int MASTER_CLK_BIT    = 2;
   localparam int SINGLE_RX_BIT     = 3;
   localparam int CONT_RX_BIT       = 4;
   localparam int NINTH_RX_BIT      = 5;
   localparam int HIGH_SPEED_BIT    = 6;
   localparam int WIDE_DIV_BIT      = 7;
   localparam int RX_INT_EN_BIT     = 8;
   localparam int PERIPH_INT_EN_BIT = 9;
   localparam int GLOBAL_INT_EN_BIT = 10;
   localparam int CTRL_W            = 11;
   // Status register field positions
   localparam int ST_NINTH_BIT      = 0;
   localparam int ST_OVERRUN_BIT    = 1;
   localparam int ST_FLAG_BIT       = 2;
   localparam int ST_COUNT_LSB      = 3;
   // Interrupt status bits
   localparam int IRQ_RX_BIT        = 0;
   localparam int IRQ_OVR_BIT       = 1;
   // Reset values
   localparam logic [10:0] CTRL_RST = 11'h000;
   localparam logic [7:0]  DIV_RST  = 8'h00;
   localparam logic [1:0]  MASK_RST = 2'h0;
   localparam logic [31:0] UNMAPPED_DATA = 32'hdeadbeef;
   // Divider prescales: clocked mode /4, async fast /4, async slow wide /16, async slow narrow /64
   localparam logic [5:0] PRESCALE_SYNC   = 6'h04;
   localparam logic [5:0] PRESCALE_SLOW   = 6'h10;
   localparam logic [5:0] PRESCALE_NARROW = 6'h40;
   localparam int FIFO_DEPTH = 2;
   localparam int CHAR_W     = 9;
endpackage

// [verilog/smr_rx_fifo.sv]
`timescale 1ns/1ps
// Two-character receive store; read data come from a register
module smr_rx_fifo (
   input  wire logic       core_clk_i,
   input  wire logic       clr_i,
   input  wire logic       push_i,
   input  wire logic [8:0] push_data_i,
   input  wire logic       pop_i,
   output logic [8:0]      head_o,
   output logic [1:0]      count_o
);
   logic [8:0] mem_q [smr_pkg::FIFO_DEPTH];
   logic       wr_q;
   logic       rd_q;
   logic [1:0] count_q;
   logic       push_ok;
   logic       rd_nx;

   assign push_ok = push_i && count_q != 2'h2;
   assign rd_nx   = rd_q ^ (pop_i && count_q != 2'h0);

   always_ff @(posedge core_clk_i) begin
      if (clr_i) begin
         wr_q    <= 1'b0;
         rd_q    <= 1'b0;
         count_q <= 2'h0;
      end else begin
         if (push_i && count_q != 2'h2) begin
            wr_q <= ~wr_q;
         end
         if (pop_i && count_q != 2'h0) begin
            rd_q <= ~rd_q;
         end
         count_q <= count_q + 2'((push_i && count_q != 2'h2) ? 1 : 0)
                            - 2'((pop_i && count_q != 2'h0) ? 1 : 0);
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (push_i && count_q != 2'h2) begin
         mem_q[wr_q] <= push_data_i;
      end
   end

   // Head shows the oldest unread character after this edge, so status and count never run ahead of it
   always_ff @(posedge core_clk_i) begin
      if (clr_i) begin
         head_o <= 9'h000;
      end else if (push_ok && wr_q == rd_nx) begin
         head_o <= push_data_i;
      end else begin
         head_o <= mem_q[rd_nx];
      end
   end

   assign count_o = count_q;
endmodule

// [verilog/smr_baud_gen.sv]
`timescale 1ns/1ps
// Bit tick generator: one tick each prescale*(divisor+1) system clocks
module smr_baud_gen (
   input  wire logic        core_clk_i,
   input  wire logic        run_i,
   input  wire logic [15:0] divisor_i,
   input  wire logic [5:0]  prescale_i,
   output logic             tick_o
);
   logic [15:0] div_cnt_q;
   logic [5:0]  pre_cnt_q;

   always_ff @(posedge core_clk_i) begin
      if (!run_i) begin
         div_cnt_q <= 16'h0000;
         pre_cnt_q <= 6'h00;
         tick_o    <= 1'b0;
      end else begin
         tick_o <= 1'b0;
         if (pre_cnt_q == prescale_i - 6'h01) begin
            pre_cnt_q <= 6'h00;
            if (div_cnt_q == divisor_i) begin
               div_cnt_q <= 16'h0000;
               tick_o    <= 1'b1;
            end else begin
               div_cnt_q <= div_cnt_q + 16'h0001;
            end
         end else begin
            pre_cnt_q <= pre_cnt_q + 6'h01;
         end
      end
   end
endmodule

// [sim/smr_slave_model.sv]
`timescale 1ns/1ps
// Serial slave clocked by the port: shifts queued characters out LSB first
module smr_slave_model (
   input  wire logic clock_line_i,
   output logic      data_o
);
   logic [8:0] chars_q[$];
   logic [8:0] cur_q;
   int         nbits;
   int         idx;
   logic       busy;

   initial begin
      data_o = 1'b1;
      nbits = 8;
      idx = 0;
      busy = 1'b0;
      cur_q = 9'h000;
   end

   task automatic load(input logic [8:0] c);
      chars_q.push_back(c);
      if (!busy) begin
         cur_q = chars_q.pop_front();
         busy = 1'b1;
         idx = 0;
         data_o = cur_q[0];
      end
   endtask

   // Next bit changes on the falling edge so it is steady at the sampling rise
   always @(negedge clock_line_i) begin
      if (busy) begin
         idx = idx + 1;
         if (idx < nbits) begin
            data_o = cur_q[idx];
         end else if (chars_q.size() > 0) begin
            cur_q = chars_q.pop_front();
            idx = 0;
            data_o = cur_q[0];
         end else begin
            busy = 1'b0;
            // Released line: show the opposite of the last bit, never a stale copy
            data_o = ~data_o;
         end
      end
   end
endmodule

// [sim/testbench.sv]
`timescale 1ns/1ps
module testbench;
   localparam int          LIMIT = 30000;
   localparam logic [31:0] BASE  = (32'h1 << smr_pkg::CLOCKED_MODE_BIT) | (32'h1 << smr_pkg::PORT_EN_BIT)
                                 | (32'h1 << smr_pkg::MASTER_CLK_BIT) | (32'h1 << smr_pkg::WIDE_DIV_BIT);
   localparam logic [31:0] SGL   = 32'h1 << smr_pkg::SINGLE_RX_BIT;
   localparam logic [31:0] CNT   = 32'h1 << smr_pkg::CONT_RX_BIT;
   localparam logic [31:0] NIN   = 32'h1 << smr_pkg::NINTH_RX_BIT;
   localparam logic [31:0] RXIE  = 32'h1 << smr_pkg::RX_INT_EN_BIT;
   localparam logic [31:0] ALLIE = RXIE | (32'h1 << smr_pkg::PERIPH_INT_EN_BIT)
                                 | (32'h1 << smr_pkg::GLOBAL_INT_EN_BIT);
   localparam int          DIV   = 3;

   logic        core_clk_i;
   logic        rst_n_i;
   logic [5:0]  avs_address_i;
   logic        avs_read_i;
   logic        avs_write_i;
   logic [31:0] avs_writedata_i;
   logic [31:0] avs_readdata_o;
   logic        avs_waitrequest_o;
   logic        data_line_i;
   logic        data_line_o;
   logic        data_line_oe_o;
   logic        clock_line_o;
   logic        clock_line_oe_o;
   logic        irq_o;
   logic        clk_prev;
   logic [31:0] rd;
   int          err_count;
   int          checked;
   int          cyc;
   int          rises;
   int          last_rise;
   int          period;

   smr_top u_dut (
      .core_clk_i        (core_clk_i),
      .rst_n_i           (rst_n_i),
      .avs_address_i     (avs_address_i),
      .avs_read_i        (avs_read_i),
      .avs_write_i       (avs_write_i),
      .avs_writedata_i   (avs_writedata_i),
      .avs_readdata_o    (avs_readdata_o),
      .avs_waitrequest_o (avs_waitrequest_o),
      .data_line_i       (data_line_i),
      .data_line_o       (data_line_o),
      .data_line_oe_o    (data_line_oe_o),
      .clock_line_o      (clock_line_o),
      .clock_line_oe_o   (clock_line_oe_o),
      .irq_o             (irq_o)
   );

   smr_slave_model u_slave (
      .clock_line_i (clock_line_o),
      .data_o       (data_line_i)  // Plain digital receive pin, no analog select in front
   );

   initial begin
      core_clk_i = 1'b0;
      forever #50 core_clk_i = ~core_clk_i;
   end

   // Cycle count, clock-line rise tracking and hang guard
   always @(posedge core_clk_i) begin
      cyc = cyc + 1;
      if (clock_line_o === 1'b1 && clk_prev === 1'b0) begin
         rises = rises + 1;
         period = cyc - last_rise;
         last_rise = cyc;
      end
      clk_prev = clock_line_o;
      if (cyc == LIMIT) begin
         err_count = err_count + 1;
         test_done();
      end
   end

   task automatic test_done();
      $display("checks %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
      checked = checked + 1;
      if (got !== exp) begin
         err_count = err_count + 1;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic cmpb(input string what, input logic exp, input logic got);
      checked = checked + 1;
      if (got !== exp) begin
         err_count = err_count + 1;
         $display("BAD %s expected %b seen %b", what, exp, got);
      end
   endtask

   // Request held until waitrequest is seen low; only the cycle limit ends a hang
   task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
      @(posedge core_clk_i);
      avs_address_i <= a;
      avs_writedata_i <= d;
      avs_write_i <= wr;
      avs_read_i <= ~wr;
      do begin
         @(posedge core_clk_i);
      end while (avs_waitrequest_o !== 1'b0);
      rd = avs_readdata_o;
      avs_write_i <= 1'b0;
      avs_read_i <= 1'b0;
   endtask

   task automatic wait_status(input int b);
      do begin
         bus(1'b0, smr_pkg::A_STATUS, 32'h0);
      end while (rd[b] !== 1'b1);
   endtask

   task automatic t_enable();
      bus(1'b0, smr_pkg::A_CTRL, 32'h0);
      cmp("ctrl reset", 32'(smr_pkg::CTRL_RST), rd);
      bus(1'b0, smr_pkg::A_INT_MASK, 32'h0);
      cmp("mask reset", 32'(smr_pkg::MASK_RST), rd);
      bus(1'b1, smr_pkg::A_DIV_LO, DIV);
      bus(1'b1, smr_pkg::A_DIV_HI, 32'h0);
      bus(1'b1, smr_pkg::A_CTRL, BASE & ~(32'h1 << smr_pkg::MASTER_CLK_BIT));
      repeat (3) @(posedge core_clk_i);
      cmpb("clk oe no master", 1'b0, clock_line_oe_o);
      bus(1'b1, smr_pkg::A_CTRL, BASE);
      repeat (3) @(posedge core_clk_i);
      cmpb("clk oe master", 1'b1, clock_line_oe_o);
      cmpb("data oe", 1'b0, data_line_oe_o);
      cmpb("data out", 1'b0, data_line_o);
      bus(1'b1, 6'h1c, 32'hffff_ffff);
      bus(1'b0, smr_pkg::A_CTRL, 32'h0);
      cmp("ctrl after unmapped", BASE, rd);
   endtask

   task automatic t_single();
      int r0;
      u_slave.nbits = 8;
      u_slave.load(9'h0a5);
      bus(1'b1, smr_pkg::A_CTRL, BASE | SGL | RXIE);
      wait_status(smr_pkg::ST_FLAG_BIT);
      cmp("count one", 32'h1, 32'(rd[4:3]));
      cmp("bit period", 4 * (DIV + 1), period);
      cmpb("irq gated", 1'b0, irq_o);
      bus(1'b0, smr_pkg::A_INT_ST, 32'h0);
      cmpb("int status rx", 1'b1, rd[smr_pkg::IRQ_RX_BIT]);
      bus(1'b0, smr_pkg::A_CTRL, 32'h0);
      cmp("single cleared", BASE | RXIE, rd);
      r0 = rises;
      repeat (100) @(posedge core_clk_i);
      cmp("clock quiet", r0, rises);
      bus(1'b1, smr_pkg::A_CTRL, BASE | ALLIE);
      repeat (2) @(posedge core_clk_i);
      cmpb("irq on", 1'b1, irq_o);
      bus(1'b0, smr_pkg::A_DATA, 32'h0);
      cmp("data", 32'ha5, rd & 32'hff);
      repeat (2) @(posedge core_clk_i);
      cmpb("irq off", 1'b0, irq_o);
      bus(1'b1, smr_pkg::A_CTRL, BASE);
   endtask

   task automatic t_ninth();
      u_slave.nbits = 9;
      u_slave.load(9'h13c);
      bus(1'b1, smr_pkg::A_CTRL, BASE | NIN | SGL);
      wait_status(smr_pkg::ST_FLAG_BIT);
      cmpb("ninth bit", 1'b1, rd[smr_pkg::ST_NINTH_BIT]);
      bus(1'b0, smr_pkg::A_DATA, 32'h0);
      cmp("data low", 32'h3c, rd & 32'hff);
      bus(1'b1, smr_pkg::A_CTRL, BASE);
   endtask

   task automatic t_overrun();
      u_slave.nbits = 8;
      bus(1'b1, smr_pkg::A_INT_ST, 32'h3);
      u_slave.load(9'h011);
      u_slave.load(9'h022);
      u_slave.load(9'h033);
      bus(1'b1, smr_pkg::A_CTRL, BASE | CNT);
      wait_status(smr_pkg::ST_OVERRUN_BIT);
      cmp("count full", 32'(smr_pkg::FIFO_DEPTH), 32'(rd[4:3]));
      cmpb("irq masked", 1'b0, irq_o);
      bus(1'b1, smr_pkg::A_INT_MASK, 32'h2);
      repeat (2) @(posedge core_clk_i);
      cmpb("irq overrun", 1'b1, irq_o);
      bus(1'b0, smr_pkg::A_DATA, 32'h0);
      cmp("first kept", 32'h11, rd & 32'hff);
      bus(1'b0, smr_pkg::A_DATA, 32'h0);
      cmp("second kept", 32'h22, rd & 32'hff);
      bus(1'b1, smr_pkg::A_CTRL, BASE);
      bus(1'b0, smr_pkg::A_STATUS, 32'h0);
      cmpb("overrun cleared", 1'b0, rd[smr_pkg::ST_OVERRUN_BIT]);
      bus(1'b1, smr_pkg::A_INT_ST, 32'h2);
      bus(1'b0, smr_pkg::A_INT_ST, 32'h0);
      cmpb("int status cleared", 1'b0, rd[smr_pkg::IRQ_OVR_BIT]);
      repeat (2) @(posedge core_clk_i);
      cmpb("irq cleared", 1'b0, irq_o);
   endtask

   initial begin
      rst_n_i = 1'b0;
      avs_address_i = 6'h00;
      avs_read_i = 1'b0;
      avs_write_i = 1'b0;
      avs_writedata_i = 32'h0;
      err_count = 0;
      checked = 0;
      cyc = 0;
      rises = 0;
      last_rise = 0;
      period = 0;
      clk_prev = 1'b0;
      repeat (5) @(posedge core_clk_i);
      rst_n_i <= 1'b1;
      t_enable();
      t_single();
      t_ninth();
      t_overrun();
      test_done();
   end
endmodule
